/* pkg/bst_tap_map.vh */
// constants for the boundary-scan test access port
`ifndef BST_TAP_MAP_VH
`define BST_TAP_MAP_VH
`define BST_IR_W          3
`define BST_IR_EXTEST     3'h0
`define BST_IR_IDCODE     3'h1
`define BST_IR_SAMPLEZ    3'h2
`define BST_IR_SAMPLE     3'h4
`define BST_IR_BYPASS     3'h7
`define BST_ID_W          32
`define BST_BSR_W         8
`define BST_ST_RESET      4'h0
`define BST_ST_IDLE       4'h1
`define BST_ST_SEL_DR     4'h2
`define BST_ST_CAP_DR     4'h3
`define BST_ST_SHIFT_DR   4'h4
`define BST_ST_EXIT1_DR   4'h5
`define BST_ST_PAUSE_DR   4'h6
`define BST_ST_EXIT2_DR   4'h7
`define BST_ST_UPD_DR     4'h8
`define BST_ST_SEL_IR     4'h9
`define BST_ST_CAP_IR     4'ha
`define BST_ST_SHIFT_IR   4'hb
`define BST_ST_EXIT1_IR   4'hc
`define BST_ST_PAUSE_IR   4'hd
`define BST_ST_EXIT2_IR   4'he
`define BST_ST_UPD_IR     4'hf
`define BST_TCK_MIN_NS    50
`define BST_TCK_PH_MIN_NS 20
`define BST_TMS_RESET_N   5
`endif

/* hdl/bst_tap_port.v */
// boundary-scan test access port, tck sampled by the system clock
// Functional notes
// [R1] tap state changes only on detected test clock edges
// [R2] tms sampled at each rising test clock edge picks next state
// [R3] tdi shifted into the selected register on rising test clock edge
// [R4] tdo updated on falling test clock edge
// [R5] one instruction register, several data registers, subset only
// [R6] only extest and sample-z disturb the memory pins
// [R7] controller keeps tck period at least 50 ns, phases 20 ns
// [R8] unused port: tck held low, tms and tdi high
// [R9] reset state at power-up or after five tms-high rising edges
// [R10] tdi sampled and tdo enabled only in shift-ir or shift-dr
// [R11] 3-bit ir loads identify code at reset and capture-ir, applied at update-ir
// [R12] code 000 drives boundary outputs, 010 floats data drivers, both disable termination
// [R13] full sixteen-state tap sequence
// [R14] code 111 selects a one-bit bypass register
`include "bst_tap_map.vh"
`default_nettype none
module bst_tap_port #(
  parameter [31:0] ID_CODE = 32'h0000_0001 // arbitrary value
) (
  input  wire                  mclk_i,
  input  wire                  rst_n_i,
  input  wire                  tck_i,
  input  wire                  tms_i,
  input  wire                  tdi_i,
  input  wire [`BST_BSR_W-1:0] pin_in_i,
  output reg                   tdo_o,
  output reg                   tdo_oe_o,
  output reg  [`BST_BSR_W-1:0] bsr_out_o,
  output reg                   bsr_drive_o,
  output reg                   data_float_o,
  output reg                   input_termination_o
);
  // tck, tms and tdi pass two flops first; rst_n_i stands in for power-up
  localparam [3:0] ST_RESET    = `BST_ST_RESET;
  localparam [3:0] ST_IDLE     = `BST_ST_IDLE;
  localparam [3:0] ST_SEL_DR   = `BST_ST_SEL_DR;
  localparam [3:0] ST_CAP_DR   = `BST_ST_CAP_DR;
  localparam [3:0] ST_SHIFT_DR = `BST_ST_SHIFT_DR;
  localparam [3:0] ST_EXIT1_DR = `BST_ST_EXIT1_DR;
  localparam [3:0] ST_PAUSE_DR = `BST_ST_PAUSE_DR;
  localparam [3:0] ST_EXIT2_DR = `BST_ST_EXIT2_DR;
  localparam [3:0] ST_UPD_DR   = `BST_ST_UPD_DR;
  localparam [3:0] ST_SEL_IR   = `BST_ST_SEL_IR;
  localparam [3:0] ST_CAP_IR   = `BST_ST_CAP_IR;
  localparam [3:0] ST_SHIFT_IR = `BST_ST_SHIFT_IR;
  localparam [3:0] ST_EXIT1_IR = `BST_ST_EXIT1_IR;
  localparam [3:0] ST_PAUSE_IR = `BST_ST_PAUSE_IR;
  localparam [3:0] ST_EXIT2_IR = `BST_ST_EXIT2_IR;
  localparam [3:0] ST_UPD_IR   = `BST_ST_UPD_IR;
  // tms and tdi share one synchroniser pattern
  localparam integer N_SYNC    = 2;

  reg  [2:0]            tck_s_q;
  wire [N_SYNC-1:0]     pin_raw;
  wire [N_SYNC-1:0]     pin_s;
  reg  [3:0]            st_q;
  reg  [3:0]            st_d;
  reg  [`BST_IR_W-1:0]  ir_sh_q;
  reg  [`BST_IR_W-1:0]  ir_q;
  reg  [`BST_ID_W-1:0]  id_sh_q;
  reg  [`BST_BSR_W-1:0] bsr_sh_q;
  reg                   byp_q;
  reg                   so_d;
  wire                  tck_rise;
  wire                  tck_fall;
  wire                  tms_s;
  wire                  tdi_s;
  wire                  bsr_sel;
  genvar                g;

  // true in the two states that own the serial path
  function in_shift;
    input [3:0] st;
    begin
      in_shift = (st == ST_SHIFT_IR) | (st == ST_SHIFT_DR);
    end
  endfunction

  // both modes that take termination away from the memory pins
  function term_off;
    input [`BST_IR_W-1:0] ir;
    begin
      term_off = (ir == `BST_IR_EXTEST) | (ir == `BST_IR_SAMPLEZ);
    end
  endfunction

  // codes that put the boundary register on the path
  function on_bsr;
    input [`BST_IR_W-1:0] ir;
    begin
      on_bsr = term_off(ir) | (ir == `BST_IR_SAMPLE);
    end
  endfunction

  assign pin_raw  = {tdi_i, tms_i};
  assign tms_s    = pin_s[0];
  assign tdi_s    = pin_s[1];
  assign tck_rise = tck_s_q[1] & ~tck_s_q[2];
  assign tck_fall = ~tck_s_q[1] & tck_s_q[2];
  assign bsr_sel  = on_bsr(ir_q);

  // third tck flop only feeds the edge detector; each tck phase must span
  // at least one system clock or an edge is lost
  always @(posedge mclk_i) begin
    tck_s_q <= {tck_s_q[1:0], tck_i};
  end

  generate
    for (g = 0; g < N_SYNC; g = g + 1) begin : g_sync
      reg meta_q;
      reg sync_q;
      always @(posedge mclk_i) begin
        meta_q <= pin_raw[g];
        sync_q <= meta_q;
      end
      assign pin_s[g] = sync_q;
    end
  endgenerate

  // five tms-high edges from any state reach reset
  always @* begin
    st_d = st_q;
    case (st_q) // [R13]
      ST_RESET:    st_d = tms_s ? ST_RESET : ST_IDLE; // [R9]
      ST_IDLE:     st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:   st_d = tms_s ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR:   st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_d = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_d = tms_s ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: st_d = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_d = tms_s ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR:   st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:   st_d = tms_s ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR:   st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_d = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_d = tms_s ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: st_d = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_d = tms_s ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR:   st_d = tms_s ? ST_SEL_DR : ST_IDLE;
      default:     st_d = ST_RESET;
    endcase
  end

  // serial out bit of the register on the path
  always @* begin
    so_d = byp_q;
    if (st_q == ST_SHIFT_IR) begin
      so_d = ir_sh_q[0];
    end else if (ir_q == `BST_IR_IDCODE) begin
      so_d = id_sh_q[0];
    end else if (bsr_sel) begin
      so_d = bsr_sh_q[0];
    end
  end

  // state register moves only on a detected rising test clock edge
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q <= ST_RESET; // [R9]
    end else if (tck_rise) begin // [R1] [R2]
      st_q <= st_d;
    end
  end

  // a half-done instruction scan never changes the mode: ir_q waits for update-ir
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ir_sh_q <= `BST_IR_IDCODE;
      ir_q    <= `BST_IR_IDCODE; // [R11]
    end else if (tck_rise) begin
      case (st_q)
        ST_RESET:    ir_q    <= `BST_IR_IDCODE; // [R11]
        ST_CAP_IR:   ir_sh_q <= `BST_IR_IDCODE; // [R11]
        ST_SHIFT_IR: ir_sh_q <= {tdi_s, ir_sh_q[`BST_IR_W-1:1]}; // [R3] [R10]
        ST_UPD_IR:   ir_q    <= ir_sh_q; // [R11]
        default:     ir_q    <= ir_q;
      endcase
    end
  end

  // data registers; only the one selected by ir_q shifts
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      id_sh_q  <= {`BST_ID_W{1'b0}};
      bsr_sh_q <= {`BST_BSR_W{1'b0}};
      byp_q    <= 1'b0;
    end else if (tck_rise) begin
      if (st_q == ST_CAP_DR) begin
        id_sh_q  <= ID_CODE;
        bsr_sh_q <= pin_in_i;
        byp_q    <= 1'b0;
      end else if (st_q == ST_SHIFT_DR) begin // [R3] [R10] [R5]
        if (ir_q == `BST_IR_IDCODE) begin
          id_sh_q <= {tdi_s, id_sh_q[`BST_ID_W-1:1]};
        end else if (bsr_sel) begin
          bsr_sh_q <= {tdi_s, bsr_sh_q[`BST_BSR_W-1:1]};
        end else begin
          byp_q <= tdi_s; // [R14] private codes fall back to bypass too
        end
      end
    end
  end

  // boundary outputs move only at update-dr under extest, never mid-shift
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bsr_out_o <= {`BST_BSR_W{1'b0}};
    end else if (tck_rise && (st_q == ST_UPD_DR) && (ir_q == `BST_IR_EXTEST)) begin
      bsr_out_o <= bsr_sh_q; // [R12]
    end
  end

  // serial outputs change on the falling edge so the controller samples a settled bit
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else if (tck_fall) begin // [R4]
      tdo_o    <= so_d;
      tdo_oe_o <= in_shift(st_q); // [R10]
    end
  end

  // mode levels follow ir_q one clock later, all three together
  always @(posedge mclk_i) begin
    if (!rst_n_i) begin
      bsr_drive_o         <= 1'b0;
      data_float_o        <= 1'b0;
      input_termination_o <= 1'b1;
    end else begin
      bsr_drive_o         <= (ir_q == `BST_IR_EXTEST); // [R6] [R12]
      data_float_o        <= (ir_q == `BST_IR_SAMPLEZ); // [R12]
      input_termination_o <= ~term_off(ir_q); // [R6]
    end
  end
endmodule
`default_nettype wire

/* tb/bst_tap_props.sv */
// assertions on the test port outputs
`default_nettype none
module bst_tap_props (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       tck_i,
  input wire logic       tdo_o,
  input wire logic       tdo_oe_o,
  input wire logic [7:0] bsr_out_o,
  input wire logic       bsr_drive_o,
  input wire logic       data_float_o,
  input wire logic       input_termination_o
);
  timeunit 1ns / 1ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_tdo_fall: assert property ($changed(tdo_o) |-> !tck_i) else $error("tdo moved in high phase");
  a_oe_fall: assert property ($changed(tdo_oe_o) |-> !tck_i) else $error("oe moved in high phase");
  a_tck_still: assert property (!tck_i [*8] |-> $stable({tdo_o, bsr_out_o})) else $error("moved while idle");
  a_ext_term: assert property (bsr_drive_o [*2] |-> !input_termination_o) else $error("termination on");
  a_flt_term: assert property (data_float_o [*2] |-> !input_termination_o) else $error("termination on");
  a_mode_one: assert property (!(bsr_drive_o && data_float_o)) else $error("two modes at once");
  a_bsr_ext: assert property ($changed(bsr_out_o) |-> bsr_drive_o) else $error("cells moved");
  // two quiet cycles so a mode that has just left is not judged
  a_term_back: assert property ((!bsr_drive_o && !data_float_o) [*2] |-> input_termination_o) else $error("term off");
  c_ext: cover property (bsr_drive_o);
  c_flt: cover property (data_float_o);
  c_oe: cover property ($rose(tdo_oe_o));
endmodule
bind bst_tap_port bst_tap_props chk_u (.*);
`default_nettype wire

/* tb/bst_jtag_host.sv */
// board test controller model
`default_nettype none
module bst_jtag_host (
  input  wire logic clk_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  timeunit 1ns / 1ps;
  initial {tck_o, tms_o, tdi_o} = 3'h3;
  // 12 + 13 system clocks make the 125 ns test clock
  task automatic tick(input logic m, input logic d, output logic q);
    tms_o <= m;
    tdi_o <= d;
    repeat (12) @(posedge clk_i);
    q = tdo_i;
    tck_o <= 1'b1;
    repeat (13) @(posedge clk_i);
    tck_o <= 1'b0;
  endtask
  // an idle tick first is harmless, and it leaves reset when r is 5
  task automatic scan(input int r, input logic ir, input int n, input logic [31:0] d, output logic [31:0] q);
    logic b;
    q = 32'h0;
    repeat (r) tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
    tick(1'b1, 1'b1, b);
    if (ir) tick(1'b1, 1'b1, b);
    repeat (2) tick(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) tick(i == n - 1, d[i], q[i]);
    tick(1'b1, 1'b1, b);
    tick(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// self-checking bench for the test port
`default_nettype none
module tb_top;
  timeunit 1ns / 1ps;
  localparam logic [31:0] ID = 32'h5a3c_96e1; // arbitrary value
  logic        mclk_i = 1'b0, rst_n_i = 1'b0;
  logic [7:0]  pin_in_i = 8'h3c;
  logic [31:0] q;
  int          err_count = 0, comparisons = 0;
  wire         tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, bsr_drive_o, data_float_o, input_termination_o;
  wire  [7:0]  bsr_out_o;
  always #2.5 mclk_i = ~mclk_i;
  bst_tap_port #(.ID_CODE(ID)) dut_u (
    .mclk_i              (mclk_i),
    .rst_n_i             (rst_n_i),
    .tck_i               (tck_i),
    .tms_i               (tms_i),
    .tdi_i               (tdi_i),
    .pin_in_i            (pin_in_i),
    .tdo_o               (tdo_o),
    .tdo_oe_o            (tdo_oe_o),
    .bsr_out_o           (bsr_out_o),
    .bsr_drive_o         (bsr_drive_o),
    .data_float_o        (data_float_o),
    .input_termination_o (input_termination_o)
  );
  // a released tdo shows the inverse so a missing enable breaks the read
  bst_jtag_host host_u (.clk_i(mclk_i), .tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i),
                        .tdo_i(tdo_oe_o ? tdo_o : ~tdo_o));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] a);
    comparisons++;
    if (a !== e) $display("[ERR] %s expected %h seen %h", s, e, a);
    if (a !== e) err_count++;
  endtask
  task automatic conclude();
    if (err_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_modes();
    logic [2:0] c[4] = '{3'h7, 3'h0, 3'h2, 3'h4}, m[4] = '{3'h1, 3'h4, 3'h2, 3'h1};
    for (int k = 0; k < 4; k++) begin
      host_u.scan(0, 1'b1, 3, c[k], q);
      chk("ir", 32'h1, q);
      chk("mode", m[k], {bsr_drive_o, data_float_o, input_termination_o});
      host_u.scan(0, 1'b0, 8, 32'ha5 ^ k, q);
      chk("dr", k ? 32'h3c : 32'h4a, q);
      chk("bsr", k ? 32'ha4 : 32'h0, bsr_out_o);
    end
  endtask
  task automatic t_reset();
    host_u.scan(5, 1'b0, 32, 32'h0, q);
    chk("idcode", ID, q);
    chk("oe", 32'h0, tdo_oe_o);
  endtask
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_modes();
    t_reset();
    conclude();
  end
  initial begin
    #40us chk("watchdog", 32'h0, 32'h1);
    conclude();
  end
endmodule
`default_nettype wire
